//--- hdl/bmal_alarm.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - three read-only voltage results, 12-bit counts, upper four bits read zero
// - write-only cold threshold in temperature limits bits 7:0, resets to zero
// - write-only hot threshold in temperature limits bits 15:8, resets all ones
// - counter-check bit routes ripple counter input clock onto alarm line
// - routed clock period is charge LSB over two to the (24 minus prescaler)
// - any active alarm pulls the active-low alarm line low
// - writing clear-alarm releases the line; the bit returns to zero itself
// - alarm during clearing: release about 1us, pull low again, reset bit
// - charge register overflow sets status bit 0 and raises alarm
// - overflow alarm reasserts after 1us release unless the charge register is rewritten
// - charge upper byte at or above threshold sets status bit 1 and alarms
// - charge compare only on charge LSB change or control/charge writes
// - clear without rewrite waits for next charge LSB change to reassert
// - die temperature at or below cold threshold sets status bit 2
// - die temperature at or above hot threshold sets status bit 3
// - shutdown bit stops counting, disables peak limit, closes bypass path
// - measurements still run on request while counter is shut down
// - conversion request in shutdown starts conversions; bit clears when done
// - status bit 4 marks shutdown measurements ready, clears on status read
// - status upper byte returns latest die temperature used by comparisons
// - temperature limits at sub-address 08h, write-only, default FF00h
module bmal_alarm #(
   parameter int RELEASE_CYCLES = bmal_pkg::RELEASE_CYC
) (
   // clock, reset, enable
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   input  wire logic        i_ce,
   // register port from the serial engine
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   // charge counting and straps
   input  wire logic        i_charge_clk,
   input  wire logic [2:0]  i_peak_limit_select,
   // converter results
   input  wire logic        i_adc_done,
   input  wire logic [11:0] i_input_voltage_idle,
   input  wire logic [11:0] i_output_voltage_pulse,
   input  wire logic [11:0] i_output_voltage_idle,
   input  wire logic [7:0]  i_die_temp,
   output logic             o_adc_start,
   // power path control
   output logic             o_count_en,
   output logic             o_peak_limit_en,
   output logic             o_bypass_en,
   // alarm line, open drain
   output logic             o_alarm_n_o,
   output logic             o_alarm_n_oe,
   output logic             o_clear_busy
);
   // ***********************************
   // state and decode
   // ***********************************
   logic [15:0]                       ctrl_q;
   logic [15:0]                       temp_lim_q;
   logic [15:0]                       charge_q;
   logic [bmal_pkg::RIPPLE_W-1:0]     ripple_q;
   logic                              clk_prev_q;
   logic                              ovf_cond_q;
   logic                              eval_q;
   logic [bmal_pkg::N_ALARM-1:0]      flags_q;
   logic                              ready_q;
   logic [bmal_pkg::ADC_W-1:0]        vin_idle_q;
   logic [bmal_pkg::ADC_W-1:0]        vout_pulse_q;
   logic [bmal_pkg::ADC_W-1:0]        vout_idle_q;
   logic [7:0]                        temp_q;
   logic                              temp_valid_q;
   logic [2:0]                        ipk_q;
   logic                              ipk_taken_q;
   logic [7:0]                        rel_cnt_q;
   bmal_pkg::bmal_clr_state_t         clr_state_q;
   logic                              wr_ctrl;
   logic                              wr_charge;
   logic                              wr_temp;
   logic                              rd_status;
   logic                              shdn;
   logic                              clk_rise;
   logic                              wrap;
   logic                              clr_take;
   logic [bmal_pkg::N_ALARM-1:0]      set_vec;
   logic [bmal_pkg::RIPPLE_W-1:0]     ripple_top;
   always_comb begin
      wr_ctrl   = i_reg_wr && (i_reg_addr == bmal_pkg::ADDR_CTRL);
      wr_charge = i_reg_wr && (i_reg_addr == bmal_pkg::ADDR_CHARGE);
      wr_temp   = i_reg_wr && (i_reg_addr == bmal_pkg::ADDR_TEMP_LIM);
      rd_status = i_reg_rd && (i_reg_addr == bmal_pkg::ADDR_STATUS);
   end
   // counting stops in shutdown; bypass replaces the limited path
   assign shdn            = ctrl_q[bmal_pkg::CTRL_SHDN_BIT];
   assign o_count_en      = ~shdn;
   assign o_peak_limit_en = ~shdn;
   assign o_bypass_en     = shdn;
   assign o_alarm_n_o     = 1'b0;
   assign o_clear_busy    = ctrl_q[bmal_pkg::CTRL_CLR_BIT];
   // ripple length shrinks with prescaler: 24-M bits per charge LSB
   assign ripple_top = {bmal_pkg::RIPPLE_W{1'b1}} >>
                       ctrl_q[bmal_pkg::CTRL_PRESC_LSB +: bmal_pkg::CTRL_PRESC_W];
   assign clk_rise   = i_charge_clk && !clk_prev_q && !shdn;
   assign wrap       = clk_rise && (ripple_q == ripple_top);
   // clear is taken only while armed; a second clear inside release is ignored
   assign clr_take   = wr_ctrl && i_reg_wdata[bmal_pkg::CTRL_CLR_BIT] &&
                       (clr_state_q == bmal_pkg::BMAL_ARMED);
   // ***********************************
   // registers and charge counting
   // ***********************************
   // clear and conversion bits self-reset; others hold what was written
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q <= bmal_pkg::CTRL_RST;
      end else if (i_ce) begin
         if (wr_ctrl) begin
            ctrl_q <= i_reg_wdata;
            ctrl_q[bmal_pkg::CTRL_CLR_BIT]  <= clr_take;
            ctrl_q[bmal_pkg::CTRL_CONV_BIT] <= i_reg_wdata[bmal_pkg::CTRL_CONV_BIT] &&
                                               i_reg_wdata[bmal_pkg::CTRL_SHDN_BIT];
         end else begin
            if (clr_state_q == bmal_pkg::BMAL_RELEASE && rel_cnt_q == 8'h01) begin
               ctrl_q[bmal_pkg::CTRL_CLR_BIT] <= 1'b0;
            end
            if (i_adc_done) begin
               ctrl_q[bmal_pkg::CTRL_CONV_BIT] <= 1'b0;
            end
         end
      end
   end
   // temperature limits, write-only
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         temp_lim_q <= bmal_pkg::TEMP_LIM_RST;
      end else if (i_ce && wr_temp) begin
         temp_lim_q <= i_reg_wdata;
      end
   end
   // conversion kick when requested with the counter shut down
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_adc_start <= 1'b0;
      end else if (i_ce) begin
         o_adc_start <= wr_ctrl && i_reg_wdata[bmal_pkg::CTRL_CONV_BIT] &&
                        i_reg_wdata[bmal_pkg::CTRL_SHDN_BIT];
      end
   end
   // ripple divides the charge clock; a charge rewrite retires the overflow
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clk_prev_q <= 1'b0;
         ripple_q   <= '0;
         charge_q   <= bmal_pkg::ZERO16;
         ovf_cond_q <= 1'b0;
      end else if (i_ce) begin
         clk_prev_q <= i_charge_clk;
         if (clk_rise) begin
            ripple_q <= wrap ? '0 : ripple_q + 1'b1;
         end
         if (wr_charge) begin
            charge_q[15:8] <= i_reg_wdata[15:8];
            ovf_cond_q     <= 1'b0;
         end else if (wrap) begin
            charge_q <= charge_q + 16'h0001;
            if (charge_q == 16'hFFFF) begin
               ovf_cond_q <= 1'b1;
            end
         end
      end
   end
   function automatic logic [15:0] ctrl_body(input logic [15:0] v);
      ctrl_body                         = v;
      ctrl_body[bmal_pkg::CTRL_CLR_BIT] = 1'b0;
   endfunction : ctrl_body
   // compare strobe; a bare clear skips it, else the charge alarm comes straight back
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         eval_q <= 1'b0;
      end else if (i_ce) begin
         eval_q <= wrap || wr_charge ||
                   (wr_ctrl && ctrl_body(i_reg_wdata) != ctrl_body(ctrl_q));
      end
   end
   // ***********************************
   // alarms, measurements and status
   // ***********************************
   always_comb begin
      set_vec                   = '0;
      set_vec[bmal_pkg::ST_OVF]  = ovf_cond_q;
      set_vec[bmal_pkg::ST_CHG]  = eval_q &&
                                   (charge_q[15:8] >= ctrl_q[bmal_pkg::CTRL_THR_LSB +: 8]);
      // no comparison before the first measurement, reset temp would trip cold
      set_vec[bmal_pkg::ST_COLD] = temp_valid_q && (temp_q <= temp_lim_q[7:0]);
      set_vec[bmal_pkg::ST_HOT]  = temp_valid_q && (temp_q >= temp_lim_q[15:8]);
   end
   // set wins over clear; true conditions re-set after the clear
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flags_q <= '0;
      end else if (i_ce) begin
         flags_q <= (clr_take ? '0 : flags_q) | set_vec;
      end
   end
   // release window after a clear, then line follows the flags again
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clr_state_q <= bmal_pkg::BMAL_ARMED;
         rel_cnt_q   <= 8'h00;
      end else if (i_ce) begin
         case (clr_state_q)
            bmal_pkg::BMAL_ARMED: begin
               if (clr_take) begin
                  clr_state_q <= bmal_pkg::BMAL_RELEASE;
                  rel_cnt_q   <= 8'(RELEASE_CYCLES);
               end
            end
            bmal_pkg::BMAL_RELEASE: begin
               rel_cnt_q <= rel_cnt_q - 8'h01;
               if (rel_cnt_q == 8'h01) begin
                  clr_state_q <= bmal_pkg::BMAL_ARMED;
               end
            end
            default: clr_state_q <= bmal_pkg::BMAL_ARMED;
         endcase
      end
   end
   // line driver: counter-check routes the ripple clock, else alarm level
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_alarm_n_oe <= 1'b0;
      end else if (i_ce) begin
         if (ctrl_q[bmal_pkg::CTRL_CHECK_BIT]) begin
            o_alarm_n_oe <= ~i_charge_clk;
         end else begin
            o_alarm_n_oe <= (|flags_q) &&
                            (clr_state_q == bmal_pkg::BMAL_ARMED);
         end
      end
   end
   // results and temperature held from the last finished conversion
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         vin_idle_q   <= '0;
         vout_pulse_q <= '0;
         vout_idle_q  <= '0;
         temp_q       <= 8'h00;
         temp_valid_q <= 1'b0;
      end else if (i_ce && i_adc_done) begin
         vin_idle_q   <= i_input_voltage_idle;
         vout_pulse_q <= i_output_voltage_pulse;
         vout_idle_q  <= i_output_voltage_idle;
         temp_q       <= i_die_temp;
         temp_valid_q <= 1'b1;
      end
   end
   // ready flag: done while conversion requested; a read clears, set wins
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ready_q <= 1'b0;
      end else if (i_ce) begin
         if (i_adc_done && ctrl_q[bmal_pkg::CTRL_CONV_BIT]) begin
            ready_q <= 1'b1;
         end else if (rd_status) begin
            ready_q <= 1'b0;
         end
      end
   end
   // strap caught once, on the first enabled edge after reset
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ipk_q       <= 3'h0;
         ipk_taken_q <= 1'b0;
      end else if (i_ce && !ipk_taken_q) begin
         ipk_q       <= i_peak_limit_select;
         ipk_taken_q <= 1'b1;
      end
   end
   // read mux; write-only and unmapped addresses read as zero
   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_rdata <= bmal_pkg::ZERO16;
      end else if (i_ce && i_reg_rd) begin
         if (i_reg_addr == bmal_pkg::ADDR_CHARGE) begin
            o_reg_rdata <= charge_q;
         end else if (i_reg_addr == bmal_pkg::ADDR_STATUS) begin
            o_reg_rdata <= {temp_q, ipk_q, ready_q, flags_q};
         end else if (i_reg_addr == bmal_pkg::ADDR_VIN_IDLE) begin
            o_reg_rdata <= {4'h0, vin_idle_q};
         end else if (i_reg_addr == bmal_pkg::ADDR_VOUT_PULSE) begin
            o_reg_rdata <= {4'h0, vout_pulse_q};
         end else if (i_reg_addr == bmal_pkg::ADDR_VOUT_IDLE) begin
            o_reg_rdata <= {4'h0, vout_idle_q};
         end else begin
            o_reg_rdata <= bmal_pkg::ZERO16;
         end
      end
   end
   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   a_line_released: assert property (i_ce && !ctrl_q[5] && flags_q == '0 |=> !o_alarm_n_oe)
      else $error("alarm line driven with no alarm");
   a_alarm_pulls: assert property (i_ce && !ctrl_q[5] && |flags_q &&
                                   clr_state_q == bmal_pkg::BMAL_ARMED |=> o_alarm_n_oe)
      else $error("alarm pending but line released");
   a_check_route: assert property (i_ce && ctrl_q[5] |=> o_alarm_n_oe == !$past(i_charge_clk))
      else $error("counter check does not follow ripple clock");
   a_clear_window: assert property (i_ce && clr_take && !ctrl_q[5] && !i_reg_wdata[5]
                                    |=> o_clear_busy ##1 (!o_alarm_n_oe && o_clear_busy))
      else $error("line not released during clear window");
   a_clear_ends: assert property (i_ce && clr_take |=> ##[0:RELEASE_CYCLES] !o_clear_busy)
      else $error("clear bit did not self-reset");
   a_ovf_sets: assert property (i_ce && wrap && !wr_charge && charge_q == 16'hFFFF
                                ##1 i_ce |=> flags_q[0])
      else $error("overflow did not set flag");
   a_chg_gated: assert property (i_ce && !eval_q && !flags_q[1] && !clr_take |=> !flags_q[1])
      else $error("charge flag set without evaluation");
   a_hot_sets: assert property (i_ce && temp_valid_q && temp_q >= temp_lim_q[15:8]
                                |=> flags_q[3])
      else $error("hot alarm missed");
   a_cold_sets: assert property (i_ce && temp_valid_q && temp_q <= temp_lim_q[7:0]
                                 |=> flags_q[2])
      else $error("cold alarm missed");
   a_shdn_path: assert property (o_bypass_en == !o_count_en && o_peak_limit_en == o_count_en)
      else $error("shutdown outputs inconsistent");
   a_ready_clears: assert property (i_ce && rd_status && !i_adc_done |=> !ready_q)
      else $error("ready not cleared by status read");
   c_charge_alarm: cover property (eval_q ##1 flags_q[1] ##[1:10] o_alarm_n_oe);
   c_clear_rearm: cover property (clr_take ##[1:30] (clr_state_q == bmal_pkg::BMAL_ARMED
                                                     && o_alarm_n_oe));
   c_shdn_conv: cover property (o_adc_start ##[1:50] ready_q);
endmodule : bmal_alarm
`default_nettype wire

//--- hdl/bmal_pkg.sv
`default_nettype none
package bmal_pkg;
   // ***********************************
   // register sub-addresses
   // ***********************************
   localparam logic [7:0]  ADDR_CTRL       = 8'h01;
   localparam logic [7:0]  ADDR_CHARGE     = 8'h02;
   localparam logic [7:0]  ADDR_STATUS     = 8'h03;
   localparam logic [7:0]  ADDR_VIN_IDLE   = 8'h05;
   localparam logic [7:0]  ADDR_VOUT_PULSE = 8'h06;
   localparam logic [7:0]  ADDR_VOUT_IDLE  = 8'h07;
   localparam logic [7:0]  ADDR_TEMP_LIM   = 8'h08;

   // ***********************************
   // control register fields
   // ***********************************
   localparam int          CTRL_PRESC_LSB  = 0;
   localparam int          CTRL_PRESC_W    = 4;
   localparam int          CTRL_CLR_BIT    = 4;
   localparam int          CTRL_CHECK_BIT  = 5;
   localparam int          CTRL_SHDN_BIT   = 6;
   localparam int          CTRL_CONV_BIT   = 7;
   localparam int          CTRL_THR_LSB    = 8;
   localparam logic [15:0] CTRL_RST        = 16'hFF00;

   // ***********************************
   // status register fields
   // ***********************************
   localparam int          ST_OVF          = 0;
   localparam int          ST_CHG          = 1;
   localparam int          ST_COLD         = 2;
   localparam int          ST_HOT          = 3;
   localparam int          ST_RDY          = 4;
   localparam int          ST_IPK_LSB      = 5;
   localparam int          ST_TEMP_LSB     = 8;
   localparam int          N_ALARM         = 4;

   // ***********************************
   // widths, reset values, timing
   // ***********************************
   localparam int          ADC_W           = 12;
   localparam int          RIPPLE_W        = 24;
   localparam logic [15:0] TEMP_LIM_RST    = 16'hFF00;
   localparam logic [15:0] ZERO16          = 16'h0000;
   localparam int          RELEASE_NS      = 1000;
   localparam int          CLK_PERIOD_NS   = 50;
   localparam int          RELEASE_CYC     = (RELEASE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                             (RELEASE_NS / CLK_PERIOD_NS);

   typedef enum logic {BMAL_ARMED, BMAL_RELEASE} bmal_clr_state_t;
endpackage : bmal_pkg
`default_nettype wire

//--- sim/bmal_alarm_test.sv
`timescale 1ns/1ns
`default_nettype none
module bmal_alarm_test;
   // short release window keeps the run brief
   localparam int         RC   = 4;
   localparam logic [7:0] A_CT = bmal_pkg::ADDR_CTRL;
   localparam logic [7:0] A_CH = bmal_pkg::ADDR_CHARGE;
   localparam logic [7:0] A_ST = bmal_pkg::ADDR_STATUS;
   localparam logic [7:0] A_TL = bmal_pkg::ADDR_TEMP_LIM;
   logic        clk_sys    = 1'b0;
   logic        sys_rst    = 1'b1;
   logic        charge_clk = 1'b0;
   logic        adc_done   = 1'b0;
   logic [11:0] v_a        = 12'h000;
   logic [11:0] v_b        = 12'h000;
   logic [11:0] v_c        = 12'h000;
   logic [7:0]  die_temp   = 8'h00;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        adc_start;
   logic        count_en;
   logic        peak_en;
   logic        bypass_en;
   logic        alarm_o;
   logic        alarm_oe;
   logic        clear_busy;
   wire         alarm_n = alarm_oe ? alarm_o : 1'b1; // pull-up on the line
   int          err_total = 0;
   int          n_checks  = 0;

   always #25 clk_sys = ~clk_sys;

   bmal_alarm #(.RELEASE_CYCLES(RC)) i_bmal_alarm (
      .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_ce(1'b1),
      .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata),
      .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_charge_clk(charge_clk),
      .i_peak_limit_select(3'b101), .i_adc_done(adc_done),
      .i_input_voltage_idle(v_a), .i_output_voltage_pulse(v_b),
      .i_output_voltage_idle(v_c), .i_die_temp(die_temp), .o_adc_start(adc_start),
      .o_count_en(count_en), .o_peak_limit_en(peak_en), .o_bypass_en(bypass_en),
      .o_alarm_n_o(alarm_o), .o_alarm_n_oe(alarm_oe), .o_clear_busy(clear_busy));

   bmal_host i_bmal_host (.i_clk_sys(clk_sys), .i_rdata(reg_rdata), .o_addr(reg_addr),
      .o_wr(reg_wr), .o_wdata(reg_wdata), .o_rd(reg_rd));

   // ***********************************
   // helpers
   // ***********************************
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      i_bmal_host.rd(a, d);
      chk($sformatf("reg %h", a), exp, d);
   endtask : rchk

   task automatic pulses(input int n);
      repeat (n) begin
         charge_clk = 1'b1;
         cyc(1);
         charge_clk = 1'b0;
         cyc(1);
      end
   endtask : pulses

   // ***********************************
   // scenarios
   // ***********************************
   // conversion in shutdown, results and status readback
   task automatic t_results;
      i_bmal_host.wr(A_CT, 16'hffc0);
      chk("adc start", 16'h0001, 16'(adc_start));
      chk("bypass", 16'h0001, 16'({bypass_en, count_en, peak_en} == 3'b100));
      v_a      = 12'habc;
      v_b      = 12'hfff;
      v_c      = 12'h123;
      die_temp = 8'h80;
      adc_done = 1'b1;
      cyc(1);
      adc_done = 1'b0;
      cyc(2);
      rchk(A_ST, 16'h80b0);
      rchk(A_ST, 16'h80a0);
      rchk(bmal_pkg::ADDR_VIN_IDLE, 16'h0abc);
      rchk(bmal_pkg::ADDR_VOUT_PULSE, 16'h0fff);
      rchk(bmal_pkg::ADDR_VOUT_IDLE, 16'h0123);
      rchk(A_TL, 16'h0000);
      rchk(8'h0f, 16'h0000);
   endtask : t_results

   // hot and cold limits, clear with a condition still true, plain clear
   task automatic t_temp;
      int n;
      i_bmal_host.wr(A_TL, 16'h8000);
      cyc(3);
      chk("line hot", 16'h0000, 16'(alarm_n));
      rchk(A_ST, 16'h80a8);
      i_bmal_host.wr(A_TL, 16'hff80);
      cyc(3);
      rchk(A_ST, 16'h80ac);
      i_bmal_host.wr(A_CT, 16'hffd0);
      cyc(1);
      chk("clear busy", 16'h0001, 16'(clear_busy & alarm_n));
      n = 0;
      while (alarm_n === 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk("release span", 16'h0001, 16'(n >= RC - 1 && n <= RC + 3));
      chk("bit reset", 16'h0000, 16'(clear_busy));
      rchk(A_ST, 16'h80a4);
      i_bmal_host.wr(A_TL, 16'hff00);
      i_bmal_host.wr(A_CT, 16'hffd0);
      cyc(RC + 4);
      chk("line idle", 16'h0001, 16'(alarm_n & ~clear_busy & ~alarm_o));
      rchk(A_ST, 16'h80a0);
   endtask : t_temp

   // charge threshold, clear without rewrite, ripple count, raised limit
   task automatic t_charge;
      i_bmal_host.wr(A_CT, 16'h010f);
      chk("counting", 16'h0001, 16'({bypass_en, count_en, peak_en} == 3'b011));
      i_bmal_host.wr(A_CH, 16'h01ff);
      cyc(3);
      chk("line charge", 16'h0000, 16'(alarm_n));
      rchk(A_CH, 16'h0100);
      rchk(A_ST, 16'h80a2);
      i_bmal_host.wr(A_CT, 16'h011f);
      cyc(RC + 6);
      chk("no reassert", 16'h0001, 16'(alarm_n));
      pulses(511);
      rchk(A_CH, 16'h0100);
      chk("still quiet", 16'h0001, 16'(alarm_n));
      pulses(1);
      cyc(3);
      chk("lsb reassert", 16'h0000, 16'(alarm_n));
      rchk(A_CH, 16'h0101);
      i_bmal_host.wr(A_CT, 16'h020f);
      i_bmal_host.wr(A_CT, 16'h021f);
      cyc(RC + 6);
      chk("raised limit", 16'h0001, 16'(alarm_n));
      rchk(A_ST, 16'h80a0);
   endtask : t_charge

   // counter check routes the ripple clock onto the line
   task automatic t_check;
      i_bmal_host.wr(A_CT, 16'h022f);
      cyc(3);
      chk("check low", 16'h0000, 16'(alarm_n));
      charge_clk = 1'b1;
      cyc(3);
      chk("check high", 16'h0001, 16'(alarm_n));
      charge_clk = 1'b0;
      i_bmal_host.wr(A_CT, 16'h020f);
      cyc(3);
      chk("check off", 16'h0001, 16'(alarm_n));
   endtask : t_check

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run

   // main sequence after an eight cycle reset
   initial begin
      cyc(8);
      sys_rst = 1'b0;
      cyc(2);
      rchk(A_ST, 16'h00a0);
      t_results;
      t_temp;
      t_charge;
      t_check;
      complete_run;
   end

   // watchdog, the tests need about 1150 cycles
   initial begin
      #(50 * 6000);
      err_total++;
      complete_run;
   end
endmodule : bmal_alarm_test
`default_nettype wire

//--- sim/bmal_host.sv
`timescale 1ns/1ns
`default_nettype none
// ***********************************
// register host model
// ***********************************
module bmal_host (
   // clock and returned data
   input  wire logic        i_clk_sys,
   input  wire logic [15:0] i_rdata,
   // request lines toward the alarm logic
   output var  logic [7:0]  o_addr,
   output var  logic        o_wr,
   output var  logic [15:0] o_wdata,
   output var  logic        o_rd
);
   // idle values at time zero
   initial begin
      o_addr  = 8'h00;
      o_wr    = 1'b0;
      o_wdata = 16'h0000;
      o_rd    = 1'b0;
   end

   // whole word write, strobe one cycle wide
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge i_clk_sys);
      o_addr  = a;
      o_wdata = d;
      o_wr    = 1'b1;
      @(negedge i_clk_sys);
      o_wr    = 1'b0;
      o_wdata = ~d; // stale data is not left on the lines
   endtask : wr

   // read, data is registered one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_rd   = 1'b1;
      @(negedge i_clk_sys);
      o_rd   = 1'b0;
      d      = i_rdata;
   endtask : rd
endmodule : bmal_host
`default_nettype wire
